// ---- logic/rtc_calendar_counter.sv ----
// rtc calendar counter: bcd timekeeping chain behind a two-wire slave port
// assumes scl, sda and the 32.768 khz time base are asynchronous inputs
`default_nettype none
module rtc_calendar_counter #(
   parameter int DIV_BITS = 15
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic xtal_clk,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output var  logic sda_out,
   output var  logic sda_oe_n,
   output var  logic wave_output_pin
);
   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] last_s;
   wire  [2:0] raw = {xtal_clk, scl_in, sda_in};
   // two flops per input, third stage for edge detect
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync_a <= 3'h7;
         sync_b <= 3'h7;
         last_s <= 3'h7;
      end else begin
         sync_a <= raw;
         sync_b <= sync_a;
         last_s <= sync_b;
      end
   end
   wire xt   = sync_b[2];
   wire scl  = sync_b[1];
   wire sda  = sync_b[0];
   wire xt_rise  = xt & ~last_s[2];
   wire scl_rise = scl & ~last_s[1];
   wire scl_fall = ~scl & last_s[1];
   wire start_c = scl & last_s[1] & ~sda & last_s[0];
   wire stop_c  = scl & last_s[1] & sda & ~last_s[0];

   // ************************************************************
   // time base divider and square wave
   // ************************************************************
   rtc_pkg::rtc_time_t     tm;
   rtc_pkg::rtc_time_t     next_tm;
   logic [7:0]             ctrl;
   logic [7:0]             next_ctrl;
   logic [DIV_BITS-1:0]    div;
   logic [DIV_BITS-1:0]    next_div;
   logic                   tick;
   logic                   next_tick;
   logic                   wave;
   logic                   next_wave;
   wire  osc_stop_n = ~tm.sec[rtc_pkg::OSC_STOP_BIT];
   // divide time base to one second
   always_comb begin
      next_div  = div;
      next_tick = 1'b0;
      if (xt_rise && osc_stop_n) begin
         next_div  = div + 1'b1;
         next_tick = &div;
      end
   end
   always_comb begin
      unique case (ctrl[1:0])
         rtc_pkg::RATE_1HZ: next_wave = div[DIV_BITS-1];   // falls as the second ticks
         rtc_pkg::RATE_4K:  next_wave = div[rtc_pkg::TAP_4K];
         rtc_pkg::RATE_8K:  next_wave = div[rtc_pkg::TAP_8K];
         rtc_pkg::RATE_32K: next_wave = xt;
      endcase
      if (!ctrl[rtc_pkg::WAVE_EN_BIT] || !osc_stop_n) begin
         next_wave = 1'b0;
      end
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div             <= '0;
         tick            <= 1'b0;
         wave_output_pin <= 1'b0;
      end else begin
         div             <= next_div;
         tick            <= next_tick;
         wave_output_pin <= next_wave;
      end
   end

   // ************************************************************
   // bcd counting helpers
   // ************************************************************
   // bcd increment with wrap
   function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim,
                                          input logic [7:0] wrap);
      logic [7:0] r;
      r = wrap;
      if (v != lim) begin
         if (v[3:0] == rtc_pkg::BCD_NINE) r = {v[7:4] + 4'h1, 4'h0};
         else r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction
   function automatic logic [7:0] month_limit(input logic [7:0] m, input logic [7:0] y);
      logic [7:0] r;
      r = rtc_pkg::BCD_31;
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) r = rtc_pkg::BCD_30;
      if (m == rtc_pkg::BCD_02) begin
         r = ((y[4] ? (y[1:0] == 2'h2) : (y[1:0] == 2'h0))) ? rtc_pkg::BCD_29
                                                             : rtc_pkg::BCD_28;
      end
      return r;
   endfunction

   // ************************************************************
   // serial slave
   // ************************************************************
   rtc_pkg::rtc_state_t  st;
   rtc_pkg::rtc_state_t  next_st;
   logic [7:0]           sh;
   logic [7:0]           next_sh;
   logic [3:0]           cnt;
   logic [3:0]           next_cnt;
   logic [5:0]           ptr;
   logic [5:0]           next_ptr;
   logic                 first;
   logic                 next_first;
   logic                 rd;
   logic                 next_rd;
   logic                 drv_low;
   logic                 next_drv_low;
   logic                 wr_en;
   logic [7:0]           rd_data;
   // register read mux, unused addresses as zero
   always_comb begin
      unique case (ptr)
         rtc_pkg::REG_SECONDS: rd_data = tm.sec;
         rtc_pkg::REG_MINUTES: rd_data = tm.min;
         rtc_pkg::REG_HOURS:   rd_data = tm.hour;
         rtc_pkg::REG_WEEKDAY: rd_data = tm.wday;
         rtc_pkg::REG_DATE:    rd_data = tm.date;
         rtc_pkg::REG_MONTH:   rd_data = tm.mon;
         rtc_pkg::REG_YEAR:    rd_data = tm.year;
         rtc_pkg::REG_CONTROL: rd_data = ctrl;
         default:              rd_data = rtc_pkg::BCD_00;
      endcase
   end
   // bit engine, byte level protocol
   always_comb begin
      next_st      = st;
      next_sh      = sh;
      next_cnt     = cnt;
      next_ptr     = ptr;
      next_first   = first;
      next_rd      = rd;
      next_drv_low = drv_low;
      wr_en        = 1'b0;
      if (stop_c) begin
         next_st      = rtc_pkg::RTC_IDLE;
         next_drv_low = 1'b0;
      end else if (start_c) begin
         next_st      = rtc_pkg::RTC_ADDR;
         next_cnt     = 4'h0;
         next_drv_low = 1'b0;
      end else begin
         unique case (st)
            rtc_pkg::RTC_IDLE: ;
            rtc_pkg::RTC_ADDR, rtc_pkg::RTC_WRX: begin
               if (scl_rise) begin
                  next_sh  = {sh[6:0], sda};
                  next_cnt = cnt + 4'h1;
               end
               if (scl_fall && cnt == 4'h8) begin
                  if (st == rtc_pkg::RTC_ADDR) begin
                     if (sh[7:1] == rtc_pkg::DEV_ADDR) begin
                        next_st      = rtc_pkg::RTC_AACK;
                        next_rd      = sh[0];
                        next_first   = ~sh[0];
                        next_drv_low = 1'b1;
                     end else begin
                        next_st = rtc_pkg::RTC_IDLE;
                     end
                  end else begin
                     next_st      = rtc_pkg::RTC_AACK;
                     next_drv_low = 1'b1;
                     if (first) begin
                        next_ptr   = sh[rtc_pkg::ADDR_BITS-1:0];
                        next_first = 1'b0;
                     end else begin
                        wr_en    = 1'b1;
                        next_ptr = ptr + 6'h1;
                     end
                  end
               end
            end
            rtc_pkg::RTC_AACK: begin
               if (scl_fall) begin
                  next_cnt = 4'h0;
                  if (rd) begin
                     next_st      = rtc_pkg::RTC_TX;
                     next_sh      = rd_data;
                     next_drv_low = ~rd_data[7];
                     next_ptr     = ptr + 6'h1;
                  end else begin
                     next_st      = rtc_pkg::RTC_WRX;
                     next_drv_low = 1'b0;
                  end
               end
            end
            rtc_pkg::RTC_TX: begin
               if (scl_rise) next_cnt = cnt + 4'h1;
               if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     next_st      = rtc_pkg::RTC_MACK;
                     next_drv_low = 1'b0;
                  end else begin
                     next_sh      = {sh[6:0], 1'b0};
                     next_drv_low = ~sh[6];
                  end
               end
            end
            rtc_pkg::RTC_MACK: begin
               if (scl_rise) begin
                  next_sh = rd_data;
                  if (sda) next_st = rtc_pkg::RTC_IDLE;
               end
               if (scl_fall) begin
                  next_st      = rtc_pkg::RTC_TX;
                  next_cnt     = 4'h0;
                  next_drv_low = ~sh[7];
                  next_ptr     = ptr + 6'h1;
               end
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st       <= rtc_pkg::RTC_IDLE;
         sh       <= '0;
         cnt      <= '0;
         ptr      <= '0;
         first    <= 1'b0;
         rd       <= 1'b0;
         drv_low  <= 1'b0;
         sda_out  <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         st       <= next_st;
         sh       <= next_sh;
         cnt      <= next_cnt;
         ptr      <= next_ptr;
         first    <= next_first;
         rd       <= next_rd;
         drv_low  <= next_drv_low;
         sda_out  <= 1'b0;             // only ever drives low
         sda_oe_n <= ~next_drv_low;
      end
   end

   // ************************************************************
   // timekeeping chain and register writes
   // ************************************************************
   always_comb begin
      logic [7:0] h;
      logic       c;
      logic [7:0] lim;
      logic [7:0] sn;
      logic [7:0] hn;
      h         = tm.hour;
      c         = 1'b0;
      sn        = bcd_inc({1'b0, tm.sec[6:0]}, rtc_pkg::BCD_59, rtc_pkg::BCD_00);
      hn        = bcd_inc({3'h0, h[4:0]}, rtc_pkg::BCD_12, rtc_pkg::BCD_01);
      lim       = month_limit(tm.mon, tm.year);
      next_tm   = tm;
      next_ctrl = ctrl;
      if (tick) begin
         next_tm.sec = {1'b0, sn[6:0]};
         if (tm.sec[6:0] == rtc_pkg::BCD_59[6:0]) begin
            next_tm.min = bcd_inc(tm.min, rtc_pkg::BCD_59, rtc_pkg::BCD_00);
            if (tm.min == rtc_pkg::BCD_59) begin
               if (h[rtc_pkg::FMT12_BIT]) begin
                  next_tm.hour = {2'h1, h[5], hn[4:0]};
                  if (h[4:0] == rtc_pkg::BCD_11[4:0]) next_tm.hour[rtc_pkg::PM_BIT] = ~h[5];
                  c = (h[5:0] == {1'b1, rtc_pkg::BCD_11[4:0]});
               end else begin
                  next_tm.hour = bcd_inc({2'h0, h[5:0]}, rtc_pkg::BCD_23, rtc_pkg::BCD_00);
                  c = (h[5:0] == rtc_pkg::BCD_23[5:0]);
               end
            end
         end
         if (c) begin
            next_tm.wday = bcd_inc(tm.wday, rtc_pkg::BCD_07, rtc_pkg::BCD_01);
            next_tm.date = bcd_inc(tm.date, lim, rtc_pkg::BCD_01);
            if (tm.date == lim) begin
               next_tm.mon = bcd_inc(tm.mon, rtc_pkg::BCD_12, rtc_pkg::BCD_01);
               if (tm.mon == rtc_pkg::BCD_12) begin
                  next_tm.year = bcd_inc(tm.year, rtc_pkg::BCD_99, rtc_pkg::BCD_00);
               end
            end
         end
      end
      // bus write overrides counting; stop bit write
      if (wr_en) begin
         unique case (ptr)
            rtc_pkg::REG_SECONDS: next_tm.sec  = sh;
            rtc_pkg::REG_MINUTES: next_tm.min  = {1'b0, sh[6:0]};
            rtc_pkg::REG_HOURS:   next_tm.hour = {1'b0, sh[6:0]};
            rtc_pkg::REG_WEEKDAY: next_tm.wday = {5'h0, sh[2:0]};
            rtc_pkg::REG_DATE:    next_tm.date = {2'h0, sh[5:0]};
            rtc_pkg::REG_MONTH:   next_tm.mon  = {3'h0, sh[4:0]};
            rtc_pkg::REG_YEAR:    next_tm.year = sh;
            rtc_pkg::REG_CONTROL: next_ctrl    = sh & rtc_pkg::CTRL_MASK;
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tm   <= '{sec: 8'h80, min: 8'h00, hour: 8'h00, wday: 8'h01,
                   date: 8'h01, mon: 8'h01, year: 8'h00};
         ctrl <= rtc_pkg::CTRL_RESET;
      end else begin
         tm   <= next_tm;
         ctrl <= next_ctrl;
      end
   end
endmodule
`default_nettype wire

// ---- inc/rtc_pkg.sv ----
// package for the rtc calendar counter: register map, field layout, timing
// assumes a 20 mhz system clock and a 32.768 khz time base input
`default_nettype none
package rtc_pkg;
   // register pointer decode
   localparam int          ADDR_BITS     = 6;
   localparam logic [5:0]  REG_SECONDS   = 6'h00;
   localparam logic [5:0]  REG_MINUTES   = 6'h01;
   localparam logic [5:0]  REG_HOURS     = 6'h02;
   localparam logic [5:0]  REG_WEEKDAY   = 6'h03;
   localparam logic [5:0]  REG_DATE      = 6'h04;
   localparam logic [5:0]  REG_MONTH     = 6'h05;
   localparam logic [5:0]  REG_YEAR      = 6'h06;
   localparam logic [5:0]  REG_CONTROL   = 6'h07;
   // bus address
   localparam logic [6:0]  DEV_ADDR      = 7'h68;
   // field positions
   localparam int          OSC_STOP_BIT  = 7;
   localparam int          FMT12_BIT     = 6;
   localparam int          PM_BIT        = 5;
   localparam int          WAVE_EN_BIT   = 4;
   localparam logic [7:0]  CTRL_RESET    = 8'h03;
   localparam logic [7:0]  CTRL_MASK     = 8'h13;
   // bcd constants
   localparam logic [7:0]  BCD_59        = 8'h59;
   localparam logic [7:0]  BCD_23        = 8'h23;
   localparam logic [7:0]  BCD_12        = 8'h12;
   localparam logic [7:0]  BCD_11        = 8'h11;
   localparam logic [7:0]  BCD_01        = 8'h01;
   localparam logic [7:0]  BCD_00        = 8'h00;
   localparam logic [7:0]  BCD_99        = 8'h99;
   localparam logic [7:0]  BCD_07        = 8'h07;
   localparam logic [7:0]  BCD_02        = 8'h02;
   localparam logic [7:0]  BCD_28        = 8'h28;
   localparam logic [7:0]  BCD_29        = 8'h29;
   localparam logic [7:0]  BCD_30        = 8'h30;
   localparam logic [7:0]  BCD_31        = 8'h31;
   localparam logic [3:0]  BCD_NINE      = 4'h9;
   localparam logic [1:0]  RATE_1HZ      = 2'h0;
   localparam logic [1:0]  RATE_4K       = 2'h1;
   localparam logic [1:0]  RATE_8K       = 2'h2;
   localparam logic [1:0]  RATE_32K      = 2'h3;
   // time-base taps for the square wave rates
   localparam int          TAP_1HZ       = 14;
   localparam int          TAP_4K        = 2;
   localparam int          TAP_8K        = 1;
   // calendar time set
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] date;
      logic [7:0] mon;
      logic [7:0] year;
   } rtc_time_t;
   // serial engine states
   typedef enum logic [5:0] {
      RTC_IDLE  = 6'b000001,
      RTC_ADDR  = 6'b000010,
      RTC_AACK  = 6'b000100,
      RTC_WRX   = 6'b001000,
      RTC_TX    = 6'b010000,
      RTC_MACK  = 6'b100000
   } rtc_state_t;
endpackage
`default_nettype wire

// ---- tb/rtc_calendar_counter_checker.sv ----
// checker for the rtc two-wire pins and square wave output
// assumes it is bound onto the top module; scl/sda inputs are wire levels
`default_nettype none
module rtc_calendar_counter_checker #(
   parameter int DIV_BITS = 15
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic xtal_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic wave_output_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ************************************************************
   // bus conditions and pin relations
   // ************************************************************
   // stop: sda rises while scl stays high
   sequence stop_seen;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   // device begins pulling the data line
   sequence pull_start;
      $fell(sda_oe_n);
   endsequence
   a_open_drain: assert property (sda_out == 1'b0)
      else $error("sda output not low");
   a_reset_quiet: assert property ($fell(reset) |-> sda_oe_n [*8])
      else $error("sda pulled after reset");
   a_wave_quiet: assert property ($fell(reset) |-> !wave_output_pin [*8])
      else $error("wave active while stopped");
   a_stop_release: assert property (stop_seen |=> sda_oe_n [*8])
      else $error("sda pulled after stop");
   a_pull_scl_low: assert property (pull_start |-> !$past(scl_in))
      else $error("sda pulled with scl high");
   a_drop_scl_low: assert property ($rose(sda_oe_n) |-> !$past(scl_in))
      else $error("sda released with scl high");
   a_hold_scl_high: assert property ($rose(scl_in) |=> $stable(sda_oe_n) [*2])
      else $error("sda moved while scl high");
   a_pull_bounded: assert property (pull_start |-> ##[1:80] sda_oe_n)
      else $error("sda held low too long");
   a_wave_steady: assert property ($changed(wave_output_pin) |=> $stable(wave_output_pin) [*3])
      else $error("wave glitch");
endmodule
bind rtc_calendar_counter rtc_calendar_counter_checker #(.DIV_BITS(DIV_BITS)) u_chk (
   .clk_sys(clk_sys), .reset(reset), .xtal_clk(xtal_clk), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .wave_output_pin(wave_output_pin));
`default_nettype wire

// ---- tb/rtc_host_model.sv ----
// two-wire bus master model: start, stop, byte write and byte read
// assumes calls begin on a falling clk edge; scl low 250 ns, high 150 ns
`default_nettype none
module rtc_host_model (
   output var logic scl,
   output var logic sda_rel,
   input  wire logic sda_wire
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // bus primitives
   // ************************************************************
   // lines released, pulled up
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic start();
      #100 sda_rel = 1'b1;
      #200 scl = 1'b1;
      #150 sda_rel = 1'b0;
      #100 scl = 1'b0;
   endtask
   task automatic stop();
      #50 sda_rel = 1'b0;
      #200 scl = 1'b1;
      #150 sda_rel = 1'b1;
      #50;
   endtask
   task automatic xfer(input logic v, output logic s);
      #50 sda_rel = v;
      #200 scl = 1'b1;
      #100 s = sda_wire;
      #50 scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) xfer(b[i], s);
      xfer(1'b1, nack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, s);
         b[i] = s;
      end
      xfer(last, s);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// testbench for the rtc calendar counter through its two-wire port
// assumes DIV_BITS 8 so one second is 256 time base periods of 800 ns
`default_nettype none
`define RTC_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [7:0] rtc_byte_q_t[$];
   logic        clk_sys;
   logic        reset;
   logic        xtal_clk;
   logic        scl;
   logic        sda_rel;
   logic        sda_out;
   logic        sda_oe_n;
   logic        wave_output_pin;
   logic        nk;
   wire logic   sda_wire;
   int          err_total;
   int          checked;
   rtc_byte_q_t q;
   // ************************************************************
   // wiring, clocks, bus tasks
   // ************************************************************
   // pull-up wire and-ed with both drains
   assign sda_wire = sda_rel & (sda_oe_n | sda_out);
   rtc_calendar_counter #(.DIV_BITS(8)) u_dut (
      .clk_sys(clk_sys), .reset(reset), .xtal_clk(xtal_clk), .scl_in(scl),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .wave_output_pin(wave_output_pin));
   rtc_host_model u_host (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // free running time base, phase unrelated to clk_sys
   initial begin
      xtal_clk = 1'b0;
      #13;
      forever #400 xtal_clk = ~xtal_clk;
   end
   task automatic wr(input logic [7:0] ptr, input rtc_byte_q_t d);
      logic k;
      u_host.start();
      u_host.wbyte({rtc_pkg::DEV_ADDR, 1'b0}, k);
      `RTC_CHK(k, 1'b0)
      u_host.wbyte(ptr, k);
      foreach (d[i]) begin
         u_host.wbyte(d[i], k);
         `RTC_CHK(k, 1'b0)
      end
      u_host.stop();
   endtask
   task automatic rd(input logic [7:0] ptr, input int n, output rtc_byte_q_t r);
      logic       k;
      logic [7:0] b;
      r = {};
      u_host.start();
      u_host.wbyte({rtc_pkg::DEV_ADDR, 1'b0}, k);
      u_host.wbyte(ptr, k);
      u_host.start();
      u_host.wbyte({rtc_pkg::DEV_ADDR, 1'b1}, k);
      `RTC_CHK(k, 1'b0)
      for (int i = 0; i < n; i++) begin
         u_host.rbyte(i == n - 1, b);
         r.push_back(b);
      end
      u_host.stop();
   endtask
   task automatic chk_q(input rtc_byte_q_t got, input rtc_byte_q_t exp);
      foreach (exp[i]) `RTC_CHK(got[i], exp[i])
   endtask
   // set hour..year at 59:59, start, poll until the second rolls
   task automatic roll(input rtc_byte_q_t t, input rtc_byte_q_t e);
      // format before time, with a legal hour
      wr(8'h00, '{8'h80, 8'h59, (t[0] & 8'h40) | 8'h12});
      wr(8'h01, '{8'h59, t[0], t[1], t[2], t[3], t[4]});
      wr(8'h00, '{8'h59});
      q = '{8'h59};
      for (int k = 0; k < 12 && q[0] !== 8'h00; k++) rd(8'h00, 7, q);
      e.push_front(8'h00);
      e.push_front(8'h00);
      chk_q(q, e);
      $display("roll test done");
   endtask
   // count wave rising edges over 512 cycles
   task automatic wave(input logic [7:0] ctrl, input int lo, input int hi);
      int   n;
      logic prev;
      wr(8'h07, '{ctrl});
      n = 0;
      prev = wave_output_pin;
      repeat (512) begin
         @(negedge clk_sys);
         if (wave_output_pin === 1'b1 && prev === 1'b0) n++;
         prev = wave_output_pin;
      end
      `RTC_CHK(n >= lo && n <= hi, 1'b1)
      $display("wave test %h done", ctrl);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      reset = 1'b1;
      err_total = 0;
      checked = 0;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      rd(8'h00, 8, q);
      chk_q(q, '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03});
      $display("reset test done");
      u_host.start();
      u_host.wbyte(8'ha0, nk);
      u_host.stop();
      `RTC_CHK(nk, 1'b1)
      wr(8'h45, '{8'h07});
      rd(8'h05, 1, q);
      `RTC_CHK(q[0], 8'h07)
      rd(8'h08, 1, q);
      `RTC_CHK(q[0], 8'h00)
      $display("address test done");
      roll('{8'h23, 8'h07, 8'h31, 8'h12, 8'h99}, '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
      roll('{8'h71, 8'h03, 8'h28, 8'h02, 8'h01}, '{8'h52, 8'h04, 8'h01, 8'h03, 8'h01});
      roll('{8'h23, 8'h05, 8'h28, 8'h02, 8'h00}, '{8'h00, 8'h06, 8'h29, 8'h02, 8'h00});
      roll('{8'h23, 8'h06, 8'h30, 8'h04, 8'h00}, '{8'h00, 8'h07, 8'h01, 8'h05, 8'h00});
      roll('{8'h51, 8'h02, 8'h15, 8'h06, 8'h10}, '{8'h72, 8'h02, 8'h15, 8'h06, 8'h10});
      roll('{8'h72, 8'h02, 8'h15, 8'h06, 8'h10}, '{8'h61, 8'h02, 8'h15, 8'h06, 8'h10});
      roll('{8'h09, 8'h01, 8'h09, 8'h09, 8'h09}, '{8'h10, 8'h01, 8'h09, 8'h09, 8'h09});
      wave(8'h13, 31, 33);
      wave(8'h12, 7, 9);
      wave(8'h11, 3, 5);
      wave(8'h10, 0, 1);
      wave(8'h03, 0, 0);
      wr(8'h00, '{8'h80});
      wave(8'h13, 0, 0);
      end_sim();
   end
   // watchdog against a hung bus or poll
   initial begin
      #4_000_000;
      err_total++;
      end_sim();
   end
endmodule
`default_nettype wire
